// file: link_regs_pkg.sv
// Package for the serial link test and status register group.
// Assumes a byte-wide host register port with one-cycle read latency.
package link_regs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_TEST_PATTERN = 12'h205;
  localparam logic [11:0] OFS_IDENTIFIER   = 12'h206;
  localparam logic [11:0] OFS_COMMA_SEL    = 12'h207;
  localparam logic [11:0] OFS_STATUS       = 12'h208;
  localparam logic [11:0] OFS_IRQ_MASK     = 12'h20a;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] RST_TEST_PATTERN = 5'h00;
  localparam logic [7:0] RST_IDENTIFIER   = 8'h00;
  localparam logic [1:0] RST_COMMA_SEL    = 2'h0;
  localparam logic [1:0] RST_IRQ_MASK     = 2'h0;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int ST_LINK_UP   = 6;
  localparam int ST_SYNC      = 5;
  localparam int ST_REALIGNED = 4;
  localparam int ST_MULTIFRAME_PHASE_SET_FLAG   = 3;
  localparam int ST_SER_LOCK  = 2;
  localparam int ST_SMP_LOCK  = 0;

  // ----------------------------------------------------------------
  // Lane output kinds and comma characters
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    LANE_DATA, LANE_PRBS7, LANE_PRBS15, LANE_PRBS23, LANE_RAMP,
    LANE_TRANSPORT, LANE_D215, LANE_K285, LANE_REP_ILA, LANE_MRPAT,
    LANE_HOLD_LOW, LANE_HOLD_HIGH, LANE_PRBS9, LANE_PRBS31,
    LANE_CLOCK_PAT, LANE_K287
  } lane_kind_t;

  typedef enum logic [1:0] {
    COMMA_K287, COMMA_K281, COMMA_K285, COMMA_NONE
  } comma_t;

  localparam logic [15:0] CLOCK_PATTERN = 16'h00ff;
  localparam logic [7:0]  K287_CODE     = 8'hfc;
  localparam logic [7:0]  K281_CODE     = 8'h3c;
  localparam logic [7:0]  K285_CODE     = 8'hbc;

endpackage

// file: link_regs.sv
// Control and status registers of the serial link transmitter.
// Assumes status inputs from other clock domains arrive raw; the
// lane encoders consume the decoded pattern and comma outputs.
`timescale 1ns/100ps

// Function
// RULE_01: Five-bit pattern select; zero means normal sample data on lanes.
// RULE_02: Values 1,2,3,13,14 select PRBS 7,15,23,9,31 on every lane.
// RULE_03: Value 4 ramp, 5 transport layer pattern, 6 repeated D21.5.
// RULE_04: Values 7,8,9,16 work only while an 8B/10B link mode is chosen.
// RULE_05: Value 10 holds serial outputs low, value 11 holds them high.
// RULE_06: Value 15 sends clock pattern 0x00FF; 12 and 17-31 are reserved.
// RULE_07: Software changes pattern, identifier, comma only with link disabled.
// RULE_08: Eight-bit identifier is sent in second alignment multiframe.
// RULE_09: Comma select: 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved.
// RULE_10: End-of-frame comma inserted opportunistically, 8B/10B modes only.
// RULE_11: Software keeps comma 0 for standard receivers, 1 or 2 otherwise.
// RULE_12: Status bit 6 reads one while the link is up.
// RULE_13: Status bit 5 is zero while sync request asserted, else one.
// RULE_14: Status bit 4 set on SYSREF realignment, cleared by writing one.
// RULE_15: Status bit 3 set by first SYSREF after enable, write one clears.
// RULE_16: Status bit 2 reads high while serializer PLL is locked.
// RULE_17: Status bit 0 reads high while sampling PLL is locked.
// RULE_18: Software writes reset values into reserved fields.
// RULE_19: Writing zero leaves sticky flags; live status bits ignore writes.
module link_regs
  import link_regs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Host register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Link context
  input  wire logic        link_enable,
  input  wire logic        mode_is_8b10b,
  input  wire logic        sysref_event,
  input  wire logic        sysref_realign,
  // Raw status, foreign domains
  input  wire logic        link_up_raw,
  input  wire logic        sync_req_n_raw,
  input  wire logic        serializer_pll_lock,
  input  wire logic        sampling_pll_lock,
  // To lane encoders, plus the interrupt output
  output lane_kind_t       lane_kind,
  output logic      [7:0]  lane_align_identifier,
  output logic      [7:0]  frame_end_comma_code,
  output logic             frame_end_comma_en,
  output logic      [15:0] clock_pattern,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [4:0] test_pattern_select_q;
  logic [7:0] identifier_q;
  logic [1:0] comma_sel_q;
  logic [1:0] irq_mask_q;
  logic       realigned_q;
  logic       multiframe_phase_set_flag_q;
  logic       multiframe_phase_set_flag_seen_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [7:0] status_rd;
  logic [7:0] rdata_q;
  logic       wr_pattern;
  logic       wr_ident;
  logic       wr_comma;
  logic       wr_status;
  logic       wr_mask;
  lane_kind_t kind_d;
  comma_t     comma_d;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Reprogramming while the link runs is a software fault; not blocked
  assign wr_pattern = reg_wr && (reg_addr == OFS_TEST_PATTERN); // RULE_07
  assign wr_ident   = reg_wr && (reg_addr == OFS_IDENTIFIER);
  assign wr_comma   = reg_wr && (reg_addr == OFS_COMMA_SEL);
  assign wr_status  = reg_wr && (reg_addr == OFS_STATUS);
  assign wr_mask    = reg_wr && (reg_addr == OFS_IRQ_MASK);

  // Pattern select, reserved upper bits are not stored
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      test_pattern_select_q <= RST_TEST_PATTERN;
    end else if (wr_pattern) begin
      test_pattern_select_q <= reg_wdata[4:0]; // RULE_01
    end
  end

  // Identifier for the alignment sequence
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      identifier_q <= RST_IDENTIFIER;
    end else if (wr_ident) begin
      identifier_q <= reg_wdata; // RULE_08
    end
  end

  // Comma selection
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      comma_sel_q <= RST_COMMA_SEL;
    end else if (wr_comma) begin
      comma_sel_q <= reg_wdata[1:0]; // RULE_09
    end
  end

  // Interrupt mask over the two sticky flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_mask_q <= RST_IRQ_MASK;
    end else if (wr_mask) begin
      irq_mask_q <= reg_wdata[ST_REALIGNED:ST_MULTIFRAME_PHASE_SET_FLAG];
    end
  end

  // ----------------------------------------------------------------
  // Status synchronisers
  // ----------------------------------------------------------------
  // Two stages per bit; only the second stage is read
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {link_up_raw, sync_req_n_raw,
                  serializer_pll_lock, sampling_pll_lock};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Sticky alignment flags
  // ----------------------------------------------------------------
  // Set wins over a same-cycle write-one clear; zero writes do nothing
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      realigned_q <= 1'b0;
    end else if (sysref_realign) begin
      realigned_q <= 1'b1; // RULE_14
    end else if (wr_status && reg_wdata[ST_REALIGNED]) begin
      realigned_q <= 1'b0; // RULE_19
    end
  end

  // Only the first SYSREF after enable counts; re-armed on disable
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      multiframe_phase_set_flag_seen_q <= 1'b0;
    end else if (!link_enable) begin
      multiframe_phase_set_flag_seen_q <= 1'b0;
    end else if (sysref_event) begin
      multiframe_phase_set_flag_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      multiframe_phase_set_flag_q <= 1'b0;
    end else if (link_enable && sysref_event && !multiframe_phase_set_flag_seen_q) begin
      multiframe_phase_set_flag_q <= 1'b1; // RULE_15
    end else if (wr_status && reg_wdata[ST_MULTIFRAME_PHASE_SET_FLAG]) begin
      multiframe_phase_set_flag_q <= 1'b0; // RULE_19
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Live bits come only from hardware, never from writes
  always_comb begin
    status_rd               = 8'h00;
    status_rd[ST_LINK_UP]   = sync2_q[3]; // RULE_12
    status_rd[ST_SYNC]      = sync2_q[2]; // RULE_13
    status_rd[ST_REALIGNED] = realigned_q;
    status_rd[ST_MULTIFRAME_PHASE_SET_FLAG]   = multiframe_phase_set_flag_q;
    status_rd[ST_SER_LOCK]  = sync2_q[1]; // RULE_16
    status_rd[ST_SMP_LOCK]  = sync2_q[0]; // RULE_17
  end

  // One-cycle read latency; unmapped addresses read zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_TEST_PATTERN: rdata_q <= {3'h0, test_pattern_select_q};
        OFS_IDENTIFIER:   rdata_q <= identifier_q;
        OFS_COMMA_SEL:    rdata_q <= {6'h00, comma_sel_q};
        OFS_STATUS:       rdata_q <= status_rd;
        OFS_IRQ_MASK:     rdata_q <= {3'h0, irq_mask_q, 3'h0};
        default:          rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Pattern decode
  // ----------------------------------------------------------------
  // Reserved codes and 8B/10B-only codes in other modes fall to data
  always_comb begin
    kind_d = LANE_DATA; // RULE_01
    unique case (test_pattern_select_q)
      5'h01: kind_d = LANE_PRBS7; // RULE_02
      5'h02: kind_d = LANE_PRBS15;
      5'h03: kind_d = LANE_PRBS23;
      5'h0d: kind_d = LANE_PRBS9;
      5'h0e: kind_d = LANE_PRBS31;
      5'h04: kind_d = LANE_RAMP; // RULE_03
      5'h05: kind_d = LANE_TRANSPORT;
      5'h06: kind_d = LANE_D215;
      5'h07: kind_d = mode_is_8b10b ? LANE_K285 : LANE_DATA; // RULE_04
      5'h08: kind_d = mode_is_8b10b ? LANE_REP_ILA : LANE_DATA;
      5'h09: kind_d = mode_is_8b10b ? LANE_MRPAT : LANE_DATA;
      5'h10: kind_d = mode_is_8b10b ? LANE_K287 : LANE_DATA;
      5'h0a: kind_d = LANE_HOLD_LOW; // RULE_05
      5'h0b: kind_d = LANE_HOLD_HIGH;
      5'h0f: kind_d = LANE_CLOCK_PAT; // RULE_06
      default: kind_d = LANE_DATA;
    endcase
  end

  // Comma decode; reserved code disables insertion
  always_comb begin
    unique case (comma_sel_q)
      2'h0:    comma_d = COMMA_K287; // RULE_09
      2'h1:    comma_d = COMMA_K281;
      2'h2:    comma_d = COMMA_K285;
      default: comma_d = COMMA_NONE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registered outputs to the lane encoders
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lane_kind             <= LANE_DATA;
      lane_align_identifier <= RST_IDENTIFIER;
      clock_pattern         <= 16'h0000;
    end else begin
      lane_kind             <= kind_d;
      lane_align_identifier <= identifier_q; // RULE_08
      clock_pattern         <= (kind_d == LANE_CLOCK_PAT) ?
                               CLOCK_PATTERN : 16'h0000;
    end
  end

  // Encoder inserts the comma whenever a frame end allows
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      frame_end_comma_code <= K287_CODE;
      frame_end_comma_en   <= 1'b0;
    end else begin
      unique case (comma_d)
        COMMA_K281: frame_end_comma_code <= K281_CODE;
        COMMA_K285: frame_end_comma_code <= K285_CODE;
        default:    frame_end_comma_code <= K287_CODE;
      endcase
      frame_end_comma_en   <= mode_is_8b10b &&
                              (comma_d != COMMA_NONE); // RULE_10
    end
  end

  // Interrupt level from masked sticky flags
  assign irq = |({realigned_q, multiframe_phase_set_flag_q} & irq_mask_q);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sticky_set_a: assert property ( // RULE_14
    @(posedge clk_sys) disable iff (!rst_n)
    sysref_realign |=> realigned_q)
    else $error("realign flag not set");

  zero_write_a: assert property ( // RULE_19
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_status && !reg_wdata[ST_MULTIFRAME_PHASE_SET_FLAG] && !sysref_event && multiframe_phase_set_flag_q)
      |=> multiframe_phase_set_flag_q)
    else $error("multiframe_phase_set_flag flag lost on zero write");

  first_sysref_a: assert property ( // RULE_15
    @(posedge clk_sys) disable iff (!rst_n)
    (link_enable && sysref_event && !multiframe_phase_set_flag_seen_q) |=> multiframe_phase_set_flag_q)
    else $error("first sysref did not set multiframe_phase_set_flag");

  lock_read_a: assert property ( // RULE_16
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_STATUS)
      |=> reg_rdata[ST_SER_LOCK] == $past(sync2_q[1]))
    else $error("serializer lock misread");

  prbs_map_a: assert property ( // RULE_02
    @(posedge clk_sys) disable iff (!rst_n)
    (test_pattern_select_q == 5'h0e) |=> lane_kind == LANE_PRBS31)
    else $error("prbs31 not selected");

  mode_gate_a: assert property ( // RULE_04
    @(posedge clk_sys) disable iff (!rst_n)
    (test_pattern_select_q == 5'h07 && !mode_is_8b10b)
      |=> lane_kind == LANE_DATA)
    else $error("8b10b-only pattern leaked");

  hold_low_a: assert property ( // RULE_05
    @(posedge clk_sys) disable iff (!rst_n)
    (test_pattern_select_q == 5'h0a) |=> lane_kind == LANE_HOLD_LOW)
    else $error("hold low not selected");

  comma_gate_a: assert property ( // RULE_10
    @(posedge clk_sys) disable iff (!rst_n)
    !mode_is_8b10b |=> !frame_end_comma_en)
    else $error("comma enabled outside 8b10b");

  // Live bits lag the raw level by two sync stages plus the read stage
  link_up_read_a: assert property ( // RULE_12
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_STATUS && $past(rst_n, 2))
      |=> reg_rdata[ST_LINK_UP] == $past(link_up_raw, 3))
    else $error("link up bit misread");

  sync_read_a: assert property ( // RULE_13
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_STATUS && $past(rst_n, 2))
      |=> reg_rdata[ST_SYNC] == $past(sync_req_n_raw, 3))
    else $error("sync status bit misread");

  smp_lock_read_a: assert property ( // RULE_17
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_STATUS && $past(rst_n, 2))
      |=> reg_rdata[ST_SMP_LOCK] == $past(sampling_pll_lock, 3))
    else $error("sampling lock misread");

  ramp_sel_a: assert property ( // RULE_03
    @(posedge clk_sys) disable iff (!rst_n)
    (test_pattern_select_q == 5'h04) |=> lane_kind == LANE_RAMP)
    else $error("ramp not selected");

  clock_pat_a: assert property ( // RULE_06
    @(posedge clk_sys) disable iff (!rst_n)
    (test_pattern_select_q == 5'h0f) |=> clock_pattern == CLOCK_PATTERN)
    else $error("clock pattern missing");

  comma_code_a: assert property ( // RULE_09
    @(posedge clk_sys) disable iff (!rst_n)
    (comma_sel_q == 2'h0) |=> frame_end_comma_code == K287_CODE)
    else $error("default comma code wrong");

endmodule

// file: link_far_side.sv
// Far side model: link receiver plus serializer and sampling PLLs.
// Assumes one clock; outputs are levels the register block samples.
`timescale 1ns/100ps
module link_far_side (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic link_enable,
  input  wire logic pll_upset,
  output logic      link_up_raw,
  output logic      sync_req_n_raw,
  output logic      serializer_pll_lock,
  output logic      sampling_pll_lock
);
  logic [3:0] lock_q;
  logic [3:0] sync_q;
  // ----------------------------------------------------------------
  // PLL relock after reset or upset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n || pll_upset) begin
      lock_q <= 4'h0;
    end else if (lock_q != 4'hf) begin
      lock_q <= lock_q + 4'h1;
    end
  end
  assign serializer_pll_lock = lock_q > 4'h7;
  assign sampling_pll_lock   = lock_q > 4'hb;
  // Receiver keeps sync requested until its lanes settle
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !link_enable) begin
      sync_q <= 4'h0;
    end else if (sync_q != 4'hf) begin
      sync_q <= sync_q + 4'h1;
    end
  end
  assign sync_req_n_raw = sync_q > 4'h9;
  // Link drops with the serializer PLL, so bits 6 and 5 can differ
  assign link_up_raw    = sync_req_n_raw && serializer_pll_lock;
endmodule

// file: serial_link_test_status_regs_tb_top.sv
// Self-checking bench for the link test and status registers.
// Assumes link_far_side drives the raw status levels.
`timescale 1ns/100ps
module serial_link_test_status_regs_tb_top;
  import link_regs_pkg::*;
  logic        clk_sys, rst_n, reg_wr, reg_rd, link_enable, pll_upset;
  logic        mode_is_8b10b, sysref_event, sysref_realign, irq;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, lane_align_identifier, d;
  logic [7:0]  frame_end_comma_code;
  logic        link_up_raw, sync_req_n_raw, frame_end_comma_en;
  logic        serializer_pll_lock, sampling_pll_lock, re_m, al_m, armed;
  logic [15:0] clock_pattern;
  lane_kind_t  lane_kind;
  int          failures, checks, seed, i, m, k;
  lane_kind_t  kinds [17] = '{LANE_DATA, LANE_PRBS7, LANE_PRBS15,
    LANE_PRBS23, LANE_RAMP, LANE_TRANSPORT, LANE_D215, LANE_K285,
    LANE_REP_ILA, LANE_MRPAT, LANE_HOLD_LOW, LANE_HOLD_HIGH, LANE_DATA,
    LANE_PRBS9, LANE_PRBS31, LANE_CLOCK_PAT, LANE_K287};
  logic [7:0]  commas [3] = '{K287_CODE, K281_CODE, K285_CODE};

  link_regs i_link_regs (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_enable(link_enable),
    .mode_is_8b10b(mode_is_8b10b), .sysref_event(sysref_event),
    .sysref_realign(sysref_realign), .link_up_raw(link_up_raw),
    .sync_req_n_raw(sync_req_n_raw),
    .serializer_pll_lock(serializer_pll_lock),
    .sampling_pll_lock(sampling_pll_lock), .lane_kind(lane_kind),
    .lane_align_identifier(lane_align_identifier),
    .frame_end_comma_code(frame_end_comma_code),
    .frame_end_comma_en(frame_end_comma_en),
    .clock_pattern(clock_pattern), .irq(irq));
  link_far_side i_link_far_side (.clk_sys(clk_sys), .rst_n(rst_n),
    .link_enable(link_enable), .pll_upset(pll_upset),
    .link_up_raw(link_up_raw), .sync_req_n_raw(sync_req_n_raw),
    .serializer_pll_lock(serializer_pll_lock),
    .sampling_pll_lock(sampling_pll_lock));

  // ----------------------------------------------------------------
  // Reporting and bus tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t read %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t output %h want %h", $time, got, exp);
    end
  endtask
  // Write also keeps the sticky flag model in step
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    if (a == OFS_STATUS && v[4]) re_m = 1'b0;
    if (a == OFS_STATUS && v[3]) al_m = 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk_rd(reg_rdata, exp);
    // Read data stands one cycle only, then returns to zero
    @(posedge clk_sys);
    #1 chk_rd(reg_rdata, 8'h00);
  endtask
  // Status read once the synchronisers have caught up
  task automatic rd_st();
    repeat (4) @(posedge clk_sys);
    rd(OFS_STATUS, {1'b0, link_up_raw, sync_req_n_raw, re_m, al_m,
                    serializer_pll_lock, 1'b0, sampling_pll_lock});
  endtask
  // One-cycle sysref pulse; only the first event while enabled aligns
  task automatic pulse(input logic realign);
    @(posedge clk_sys);
    sysref_realign <= realign;
    sysref_event   <= !realign;
    @(posedge clk_sys);
    sysref_realign <= 1'b0;
    sysref_event   <= 1'b0;
    if (realign) re_m = 1'b1;
    if (!realign && link_enable && armed) al_m = 1'b1;
    if (!realign && link_enable) armed = 1'b0;
    #1;
  endtask

  // Bounded wait for the far side to bring the link up
  task automatic wait_up();
    for (k = 0; k < 100 && link_up_raw !== 1'b1; k++) @(posedge clk_sys);
    if (k == 100) begin
      failures++;
      close_out();
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, reg_wr, reg_rd, link_enable, pll_upset, mode_is_8b10b} = '0;
    {sysref_event, sysref_realign, re_m, al_m} = '0;
    reg_addr  = 12'h000;
    reg_wdata = 8'h00;
    armed     = 1'b1;
    seed      = 41;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(OFS_TEST_PATTERN, 8'h00);
    rd(OFS_IDENTIFIER, 8'h00);
    rd(OFS_COMMA_SEL, 8'h00);
    rd(OFS_IRQ_MASK, 8'h00);
    rd(12'h209, 8'h00);
    chk_out({8'h00, frame_end_comma_code}, {8'h00, K287_CODE});
    // Every pattern code in both link modes, link disabled throughout
    for (m = 0; m < 2; m++) begin
      @(posedge clk_sys) mode_is_8b10b <= m[0];
      for (i = 0; i < 32; i++) begin
        wr(OFS_TEST_PATTERN, 8'(i));
        @(posedge clk_sys);
        #1 chk_out({12'h000, lane_kind}, {12'h000, (i > 16) ? LANE_DATA
          : (m == 0 && i inside {7, 8, 9, 16}) ? LANE_DATA
          : kinds[i]});
        chk_out(clock_pattern, (i == 15) ? 16'h00ff : 16'h0000);
        rd(OFS_TEST_PATTERN, 8'(i));
      end
      for (i = 0; i < 4; i++) begin
        wr(OFS_COMMA_SEL, 8'(i));
        @(posedge clk_sys);
        #1 chk_out({15'h0, frame_end_comma_en},
          16'(m == 1 && i != 3));
        if (i < 3) begin
          chk_out({8'h00, frame_end_comma_code},
            {8'h00, commas[i]});
        end
        rd(OFS_COMMA_SEL, 8'(i));
      end
    end
    wr(OFS_COMMA_SEL, 8'h00);
    for (i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr(OFS_IDENTIFIER, d);
      @(posedge clk_sys);
      #1 chk_out({8'h00, lane_align_identifier}, {8'h00, d});
      rd(OFS_IDENTIFIER, d);
    end
    // Sticky flags, mask and interrupt
    wr(OFS_IRQ_MASK, 8'h18);
    rd(OFS_IRQ_MASK, 8'h18);
    pulse(1'b1);
    chk_out({15'h0, irq}, 16'h0001);
    rd_st();
    wr(OFS_STATUS, 8'h65);
    rd_st();
    wr(OFS_STATUS, 8'h10);
    chk_out({15'h0, irq}, 16'h0000);
    rd_st();
    @(posedge clk_sys) link_enable <= 1'b1;
    wait_up();
    pulse(1'b0);
    rd_st();
    wr(OFS_IRQ_MASK, 8'h10);
    chk_out({15'h0, irq}, 16'h0000);
    wr(OFS_IRQ_MASK, 8'h18);
    chk_out({15'h0, irq}, 16'h0001);
    // Zero in the multiframe_phase_set_flag bit must leave the flag set
    wr(OFS_STATUS, 8'h10);
    chk_out({15'h0, irq}, 16'h0001);
    rd_st();
    wr(OFS_STATUS, 8'h08);
    pulse(1'b0);
    rd_st();
    @(posedge clk_sys) link_enable <= 1'b0;
    armed = 1'b1;
    rd_st();
    // Link must be settled before the status read is predictable
    @(posedge clk_sys) link_enable <= 1'b1;
    wait_up();
    pulse(1'b0);
    rd_st();
    @(posedge clk_sys) pll_upset <= 1'b1;
    @(posedge clk_sys);
    pll_upset <= 1'b0;
    rd_st();
    repeat (9) @(posedge clk_sys);
    rd_st();
    // Reset in mid-run returns registers and outputs to defaults
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(OFS_IDENTIFIER, 8'h00);
    rd(OFS_IRQ_MASK, 8'h00);
    rd(OFS_TEST_PATTERN, 8'h00);
    chk_out({8'h00, lane_align_identifier}, 16'h0000);
    chk_out({12'h000, lane_kind}, {12'h000, LANE_DATA});
    chk_out({15'h0, irq}, 16'h0000);
    close_out();
  end
endmodule
